/* File: core/write_permission_gate.sv */
`timescale 1ns/10ps
// Function
// (RULE1) nonvolatile cycle launches at STOP only after whole, well-formed frame.
// (RULE2) protect pin high: only volatile wiper writes, and only when unlocked.
// (RULE3) protect low, lock set: no wiper writes, array outside range, status allowed.
// (RULE4) any START activates; wrong device select returns to standby after 9 pulses. Code ignores a START during the nonvolatile write cycle.
// (RULE5) STOP without launch: standby 200 ns later; with launch: after write time.
// (RULE6) writes need the write-enable latch; otherwise aborted without acknowledge.
// (RULE7) lock pair 00 none, 01 C0h-FFh, 10 80h-FFh, 11 everything.
// (RULE8) protect pin is active high and disables every nonvolatile write.
// (RULE9) a refused write leaves wipers, array and status untouched.
module write_permission_gate
    import write_gate_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NONVOLATILE_WRITE_CYCLES
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic WRITE_PROTECT_I,
    input wire logic START_I,
    input wire logic STOP_I,
    input wire logic SCL_PULSE_I,
    input wire logic DEV_MATCH_I,
    input wire logic WR_REQ_I,
    input wire logic [2:0] WR_KIND_I,
    input wire logic [7:0] WR_ADDR_I,
    input wire logic [7:0] WR_DATA_I,
    output logic ACK_O,
    output logic REFUSE_O,
    output logic ACTIVE_O,
    output logic NV_BUSY_O,
    output logic ARRAY_WE_O,
    output logic [7:0] ARRAY_ADDR_O,
    output logic [7:0] ARRAY_DATA_O,
    output logic [7:0] WIPER0_O,
    output logic [7:0] WIPER1_O
);

    typedef struct packed {
        power_state_t state;
        logic [31:0] timer;
        logic [3:0] bit_cnt;
        logic [7:0] byte_cnt;
        logic frame_ok;
        logic pend_valid;
        logic [2:0] pend_kind;
        logic [7:0] pend_addr;
        logic [7:0] pend_data;
        logic write_enable_latch;
        logic [1:0] lock;
        logic [7:0] wiper0;
        logic [7:0] wiper1;
        logic ack;
        logic refuse;
        logic arr_we;
        logic [7:0] arr_addr;
        logic [7:0] arr_data;
        logic pready;
        logic [31:0] prdata;
        logic active;
        logic nv_busy;
    } gate_state_t;

    gate_state_t cur;
    gate_state_t next_cur;
    logic allow;
    logic apb_setup;
    logic apb_write;
    logic end_of_byte;

    write_permission u_perm (
        .wp_i(WRITE_PROTECT_I),
        .wel_i(cur.write_enable_latch),
        .lock_i(cur.lock),
        .kind_i(WR_KIND_I),
        .addr_i(WR_ADDR_I),
        .allow_o(allow)
    );

    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_write = PSEL_I && PENABLE_I && cur.pready && PWRITE_I;
    assign end_of_byte = SCL_PULSE_I && (cur.bit_cnt == PULSES_PER_BYTE - 4'h1);

    always_comb begin
        next_cur = cur;
        next_cur.ack = 1'b0;
        next_cur.refuse = 1'b0;
        next_cur.arr_we = 1'b0;
        next_cur.pready = apb_setup;

        // clock-pulse bookkeeping inside a frame
        if (SCL_PULSE_I && cur.state == ST_ACTIVE) begin
            next_cur.bit_cnt = end_of_byte ? 4'h0 : cur.bit_cnt + 4'h1;
            if (end_of_byte) begin
                next_cur.byte_cnt = cur.byte_cnt + 8'h01;
                // ninth pulse of the first byte decides whether we are addressed
                if (cur.byte_cnt == 8'h00 && !DEV_MATCH_I) begin
                    next_cur.state = ST_STANDBY; // RULE4
                end
            end
        end

        // write requests from the serial front end
        if (WR_REQ_I) begin
            if (allow && cur.state == ST_ACTIVE) begin
                next_cur.ack = 1'b1;
                case (write_kind_t'(WR_KIND_I))
                    KIND_WIPER_VOL: begin
                        if (WR_ADDR_I[0]) begin
                            next_cur.wiper1 = WR_DATA_I;
                        end else begin
                            next_cur.wiper0 = WR_DATA_I;
                        end
                    end
                    KIND_STAT_VOL: next_cur.write_enable_latch = WR_DATA_I[WEL_BIT];
                    default: begin
                        // nonvolatile data waits for a clean STOP before it lands
                        next_cur.pend_valid = 1'b1;
                        next_cur.pend_kind = WR_KIND_I;
                        next_cur.pend_addr = WR_ADDR_I;
                        next_cur.pend_data = WR_DATA_I;
                    end
                endcase
            end else begin
                // refused: nothing stored changes and the pending byte is dropped
                next_cur.refuse = 1'b1; // RULE6 RULE9
                next_cur.frame_ok = 1'b0; // RULE1
                next_cur.pend_valid = 1'b0; // RULE9
            end
        end

        // power-state sequencing
        case (cur.state)
            ST_STANDBY: begin
                if (START_I) begin
                    next_cur.state = ST_ACTIVE; // RULE4
                end
            end
            ST_ACTIVE: begin
                if (STOP_I) begin
                    // whole bytes only, and at least device, address and data
                    if (cur.pend_valid && cur.frame_ok && cur.bit_cnt == 4'h0
                        && cur.byte_cnt >= MIN_WRITE_BYTES && !WRITE_PROTECT_I) begin // RULE1 RULE8
                        next_cur.state = ST_NV_BUSY;
                        next_cur.timer = 32'(NV_WRITE_CYCLES - 1); // RULE5
                        case (write_kind_t'(cur.pend_kind))
                            KIND_WIPER_NV: begin
                                if (cur.pend_addr[0]) begin
                                    next_cur.wiper1 = cur.pend_data;
                                end else begin
                                    next_cur.wiper0 = cur.pend_data;
                                end
                            end
                            KIND_STAT_NV: begin
                                next_cur.lock = {cur.pend_data[LOCK_HIGH_POS], cur.pend_data[LOCK_LOW_POS]};
                            end
                            default: begin
                                next_cur.arr_we = 1'b1;
                                next_cur.arr_addr = cur.pend_addr;
                                next_cur.arr_data = cur.pend_data;
                            end
                        endcase
                    end else begin
                        next_cur.state = ST_STOP_WAIT;
                        next_cur.timer = 32'(STOP_TO_STANDBY_CYCLES - 1); // RULE5
                    end
                    next_cur.pend_valid = 1'b0; // RULE1
                end
            end
            ST_STOP_WAIT: begin
                if (START_I) begin
                    next_cur.state = ST_ACTIVE;
                end else if (cur.timer == 32'h0) begin
                    next_cur.state = ST_STANDBY; // RULE5
                end else begin
                    next_cur.timer = cur.timer - 32'h1;
                end
            end
            ST_NV_BUSY: begin
                // frames during the write cycle are ignored so requests get refused
                if (cur.timer == 32'h0) begin
                    next_cur.state = ST_STANDBY; // RULE5
                end else begin
                    next_cur.timer = cur.timer - 32'h1;
                end
            end
            default: next_cur.state = ST_STANDBY;
        endcase

        // a START opens a fresh frame count, except during the nonvolatile write cycle
        if (START_I && cur.state != ST_NV_BUSY) begin
            next_cur.bit_cnt = 4'h0;
            next_cur.byte_cnt = 8'h00;
            next_cur.frame_ok = 1'b1;
            next_cur.pend_valid = 1'b0; // RULE1
        end

        // APB writes: the latch is free, lock bits obey the protect pin
        if (apb_write && PADDR_I == ADDR_CTRL) begin
            next_cur.write_enable_latch = PWDATA_I[CTRL_WEL_POS];
            if (!WRITE_PROTECT_I) begin
                next_cur.lock = {PWDATA_I[CTRL_LOCK_HIGH_POS], PWDATA_I[CTRL_LOCK_LOW_POS]}; // RULE8
            end
        end

        // read data captured in the setup cycle, stable through the access
        if (apb_setup) begin
            case (PADDR_I)
                ADDR_CTRL: next_cur.prdata = {29'h0, cur.lock, cur.write_enable_latch};
                ADDR_STATUS: next_cur.prdata = {28'h0, WRITE_PROTECT_I, cur.pend_valid,
                                                cur.state == ST_NV_BUSY, cur.state != ST_STANDBY};
                ADDR_WIPER0: next_cur.prdata = {24'h0, cur.wiper0};
                ADDR_WIPER1: next_cur.prdata = {24'h0, cur.wiper1};
                default: next_cur.prdata = 32'h0;
            endcase
        end

        // power pins follow the next state so they leave a flop with no decode glitch
        next_cur.active = (next_cur.state != ST_STANDBY); // RULE4 RULE5
        next_cur.nv_busy = (next_cur.state == ST_NV_BUSY); // RULE5
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cur <= '0;
            cur.state <= ST_STANDBY;
            cur.lock <= LOCK_RESET;
            cur.wiper0 <= WIPER_RESET;
            cur.wiper1 <= WIPER_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign PRDATA_O = cur.prdata;
    assign PREADY_O = cur.pready;
    assign PSLVERR_O = 1'b0; // unmapped reads return zero, never an error
    assign ACK_O = cur.ack;
    assign REFUSE_O = cur.refuse;
    assign ACTIVE_O = cur.active;
    assign NV_BUSY_O = cur.nv_busy;
    assign ARRAY_WE_O = cur.arr_we;
    assign ARRAY_ADDR_O = cur.arr_addr;
    assign ARRAY_DATA_O = cur.arr_data;
    assign WIPER0_O = cur.wiper0;
    assign WIPER1_O = cur.wiper1;

endmodule

/* File: core/write_gate_pkg.sv */
package write_gate_pkg;

    // serial clock-domain timing at the 50 MHz core clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int STOP_TO_STANDBY_NS = 200;
    localparam int STOP_TO_STANDBY_CYCLES = (STOP_TO_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NONVOLATILE_WRITE_TIME_US = 10000;
    localparam int NONVOLATILE_WRITE_CYCLES = NONVOLATILE_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

    // frame shape: clock pulses per byte and bytes needed for a write
    localparam logic [3:0] PULSES_PER_BYTE = 4'h9;
    localparam logic [7:0] MIN_WRITE_BYTES = 8'h03;

    // range-lock boundaries
    localparam logic [7:0] LOCK_QUARTER_BASE = 8'hC0;
    localparam logic [7:0] LOCK_HALF_BASE = 8'h80;

    // status byte field positions
    localparam int WEL_BIT = 1;
    localparam int LOCK_LOW_POS = 3;
    localparam int LOCK_HIGH_POS = 4;

    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WIPER0 = 8'h08;
    localparam logic [7:0] ADDR_WIPER1 = 8'h0C;

    // control register fields
    localparam int CTRL_WEL_POS = 0;
    localparam int CTRL_LOCK_LOW_POS = 1;
    localparam int CTRL_LOCK_HIGH_POS = 2;

    // reset values
    localparam logic [1:0] LOCK_RESET = 2'h0;
    localparam logic [7:0] WIPER_RESET = 8'h00;

    typedef enum logic [2:0] {
        KIND_WIPER_VOL,
        KIND_WIPER_NV,
        KIND_ARRAY,
        KIND_STAT_VOL,
        KIND_STAT_NV
    } write_kind_t;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_ACTIVE,
        ST_STOP_WAIT,
        ST_NV_BUSY
    } power_state_t;

endpackage

/* File: core/write_permission.sv */
`timescale 1ns/10ps
// decides whether one write may proceed; purely combinational
module write_permission
    import write_gate_pkg::*;
(
    input wire logic wp_i,
    input wire logic wel_i,
    input wire logic [1:0] lock_i,
    input wire logic [2:0] kind_i,
    input wire logic [7:0] addr_i,
    output logic allow_o
);

    // true when the array address lies inside the locked range
    function automatic logic in_locked_range(input logic [1:0] lock, input logic [7:0] addr);
        case (lock)
            2'h1: in_locked_range = (addr >= LOCK_QUARTER_BASE); // RULE7
            2'h2: in_locked_range = (addr >= LOCK_HALF_BASE); // RULE7
            2'h3: in_locked_range = 1'b1; // RULE7
            default: in_locked_range = 1'b0;
        endcase
    endfunction

    logic locked;

    assign locked = |lock_i;

    // write-protect high blocks every nonvolatile and status write
    always_comb begin
        allow_o = 1'b0;
        if (!wel_i) begin
            allow_o = 1'b0; // RULE6
        end else if (wp_i) begin
            allow_o = (write_kind_t'(kind_i) == KIND_WIPER_VOL) && !locked; // RULE2 RULE8
        end else begin
            case (write_kind_t'(kind_i))
                KIND_WIPER_VOL: allow_o = !locked; // RULE3
                KIND_WIPER_NV: allow_o = !locked; // RULE3
                KIND_ARRAY: allow_o = !in_locked_range(lock_i, addr_i); // RULE3
                KIND_STAT_VOL: allow_o = 1'b1; // RULE3
                KIND_STAT_NV: allow_o = 1'b1; // RULE3
                default: allow_o = 1'b0;
            endcase
        end
    end

endmodule

/* File: test/gate_asserts.sv */
`timescale 1ns/10ps
module gate_asserts #(
    parameter int NV_WRITE_CYCLES = 20
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic WRITE_PROTECT_I,
    input wire logic START_I,
    input wire logic STOP_I,
    input wire logic WR_REQ_I,
    input wire logic [2:0] WR_KIND_I,
    input wire logic REFUSE_O,
    input wire logic ACK_O,
    input wire logic ACTIVE_O,
    input wire logic NV_BUSY_O,
    input wire logic ARRAY_WE_O,
    input wire logic [7:0] WIPER0_O,
    input wire logic [7:0] WIPER1_O
);
    localparam int BUSY_MAX = NV_WRITE_CYCLES + 4;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // a request taken while awake; a stop that launches no write cycle
    sequence s_req;
        WR_REQ_I && ACTIVE_O;
    endsequence
    sequence s_plain_stop;
        ACTIVE_O && STOP_I && !NV_BUSY_O ##1 !NV_BUSY_O;
    endsequence
    a_one_answer: assert property (s_req |=> ACK_O != REFUSE_O) else $error("no single answer");
    a_protect_refuse: assert property (s_req and WRITE_PROTECT_I && WR_KIND_I != 3'h0 |=> REFUSE_O)
        else $error("write passed protect");
    a_nv_cause: assert property ($rose(NV_BUSY_O) |-> $past(STOP_I) && !$past(WRITE_PROTECT_I))
        else $error("write cycle without stop");
    a_busy_hold: assert property ($rose(NV_BUSY_O) |-> (NV_BUSY_O && ACTIVE_O)[*8])
        else $error("write cycle too short");
    a_busy_ends: assert property ($rose(NV_BUSY_O) |-> ##[1:BUSY_MAX] !NV_BUSY_O)
        else $error("write cycle never ends");
    a_start_wakes: assert property (START_I |=> ACTIVE_O) else $error("start did not wake");
    a_stop_sleep: assert property (s_plain_stop |-> ACTIVE_O[*6] ##[1:5] !ACTIVE_O)
        else $error("standby timing after stop");
    a_refuse_keeps: assert property (REFUSE_O |-> !ARRAY_WE_O && $stable(WIPER0_O) && $stable(WIPER1_O))
        else $error("refused write changed state");
endmodule
bind write_permission_gate gate_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (.CORE_CLK_I, .RESET_N_I,
    .WRITE_PROTECT_I, .START_I, .STOP_I, .WR_REQ_I, .WR_KIND_I, .REFUSE_O, .ACK_O, .ACTIVE_O, .NV_BUSY_O,
    .ARRAY_WE_O, .WIPER0_O, .WIPER1_O);

/* File: test/serial_master_model.sv */
`timescale 1ns/10ps
// two-wire master, seen as the events its front end decodes
module serial_master_model (
    input wire logic clk_i,
    input wire logic ack_i,
    output logic start_o,
    output logic stop_o,
    output logic pulse_o,
    output logic match_o,
    output logic req_o,
    output logic [2:0] kind_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_o
);
    initial {start_o, stop_o, pulse_o, match_o, req_o, kind_o, addr_o, data_o} = '0;
    // one frame: start, np clock pulses, optional write byte, stop when matched
    task automatic frame(input logic m, input int np, input logic rq, input logic [2:0] k,
                         input logic [7:0] a, input logic [7:0] d, output logic ok);
        ok = 1'h0;
        @(posedge clk_i) start_o <= 1'h1;
        @(posedge clk_i) start_o <= 1'h0;
        match_o <= m;
        for (int i = 1; i <= np; i++) begin
            @(posedge clk_i) pulse_o <= 1'h1;
            @(posedge clk_i) pulse_o <= 1'h0;
            if (i == 9) match_o <= ~m;
        end
        if (rq) begin
            @(posedge clk_i) {req_o, kind_o, addr_o, data_o} <= {1'h1, k, a, d};
            @(posedge clk_i) req_o <= 1'h0;
            data_o <= ~d; // released data line stops showing the byte
            @(posedge clk_i) ok = ack_i;
        end
        // no stop for a frame the device dropped
        if (m) @(posedge clk_i) stop_o <= 1'h1;
        if (m) @(posedge clk_i) stop_o <= 1'h0;
    endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import write_gate_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, wp = 0, ok, p, we_seen = 0, busy_seen = 0;
    logic [7:0] paddr = '0, a, d, aaddr, adata, w0, w1, ew [2];
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, ack, refuse, active, busy, we, start, stop, pulse, match, req, slverr;
    logic [2:0] kind, kd;
    logic [7:0] waddr, wdata;
    logic [1:0] lk;
    logic [15:0] lfsr = 16'h000E, we_word;
    int bad_count = 0, n_compared = 0, n, busy_len = 0;
    localparam int NV_CYC = 20;
    always #10 clk = ~clk;
    serial_master_model bus (.clk_i(clk), .ack_i(ack), .start_o(start), .stop_o(stop), .pulse_o(pulse),
        .match_o(match), .req_o(req), .kind_o(kind), .addr_o(waddr), .data_o(wdata));
    write_permission_gate #(.NV_WRITE_CYCLES(NV_CYC)) DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(slverr), .WRITE_PROTECT_I(wp), .START_I(start), .STOP_I(stop),
        .SCL_PULSE_I(pulse), .DEV_MATCH_I(match), .WR_REQ_I(req), .WR_KIND_I(kind), .WR_ADDR_I(waddr),
        .WR_DATA_I(wdata), .ACK_O(ack), .REFUSE_O(refuse), .ACTIVE_O(active), .NV_BUSY_O(busy),
        .ARRAY_WE_O(we), .ARRAY_ADDR_O(aaddr), .ARRAY_DATA_O(adata), .WIPER0_O(w0), .WIPER1_O(w1));
    // pulses are short, so latch them for the checks after each frame
    always @(posedge clk) begin
        if (we) we_seen <= 1'h1;
        if (we) we_word <= {aaddr, adata};
        if (busy) busy_seen <= 1'h1;
        if (busy) busy_len <= busy_len + 1;
    end
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected permission with the latch set
    function automatic logic allowed(input logic pr, input logic [1:0] l, input logic [2:0] k, input logic [7:0] ad);
        if (pr) return k == 3'h0 && l == 2'h0;
        if (l == 2'h0) return 1'h1;
        if (k <= 3'h1) return 1'h0;
        if (k == 3'h2) return l != 2'h3 && ad < (l == 2'h1 ? LOCK_QUARTER_BASE : LOCK_HALF_BASE);
        return 1'h1;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        print_verdict();
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt, output logic [31:0] rd);
        int k;
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {1'h1, 1'h0, w, ad, dt};
        @(posedge clk) pen <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (pready !== 1'h1) hang();
        rd = prdata;
        check("slave error", slverr, 1'h0);
        {psel, pen} <= 2'h0;
    endtask
    // waits for standby, counting the cycles it took in n
    task automatic idle();
        n = 0;
        while (active !== 1'h0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (active !== 1'h0) hang();
    endtask
    initial begin
        ew = '{WIPER_RESET, WIPER_RESET};
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        apb(1'h0, ADDR_CTRL, 32'h0, q);
        check("ctrl reset", q, 32'h0);
        apb(1'h0, 8'h10, 32'h0, q);
        check("unmapped read", q, 32'h0);
        bus.frame(1'h1, 27, 1'h1, KIND_WIPER_VOL, 8'h00, 8'h5A, ok);
        check("no latch", ok, 1'h0);
        idle();
        check("stop to standby", n, STOP_TO_STANDBY_CYCLES + 1);
        for (int i = 0; i < 8; i++) begin
            {p, lk} = i[2:0];
            wp <= 1'h0;
            apb(1'h1, ADDR_CTRL, {29'h0, lk, 1'h1}, q);
            wp <= p;
            apb(1'h0, ADDR_CTRL, 32'h0, q);
            check("ctrl readback", q, {29'h0, lk, 1'h1});
            for (int k = 0; k < 7; k++) begin
                lfsr = next_rand(lfsr);
                kd = k > 4 ? 3'h2 : k[2:0];
                a = k == 5 ? LOCK_QUARTER_BASE - lfsr[0] : (k == 6 ? LOCK_HALF_BASE - lfsr[0] : lfsr[7:0]);
                d = kd == 3'h3 ? 8'h02 : (kd == 3'h4 ? {3'h0, lk, 3'h2} : lfsr[15:8]);
                bus.frame(1'h1, 27, 1'h1, kd, a, d, ok);
                check("answer", ok, allowed(p, lk, kd, a));
                if (ok && kd <= 3'h1) ew[a[0]] = d;
                idle();
                check("wiper0", w0, ew[0]);
                check("wiper1", w1, ew[1]);
                check("array write", we_seen, ok && kd == 3'h2);
                if (ok && kd == 3'h2) check("array word", we_word, {a, d});
                check("write cycle", busy_seen, ok && kd != 3'h0 && kd != 3'h3);
                check("write time", busy_len, (ok && kd != 3'h0 && kd != 3'h3) ? NV_CYC : 0);
                {we_seen, busy_seen} <= 2'h0;
                busy_len <= 0;
            end
        end
        apb(1'h0, ADDR_WIPER0, 32'h0, q);
        check("wiper0 read", q, {24'h0, ew[0]});
        apb(1'h0, ADDR_WIPER1, 32'h0, q);
        check("wiper1 read", q, {24'h0, ew[1]});
        wp <= 1'h0;
        apb(1'h1, ADDR_CTRL, 32'h1, q);
        bus.frame(1'h1, 18, 1'h1, KIND_ARRAY, 8'h10, 8'h33, ok);
        idle();
        check("short frame", we_seen | busy_seen, 1'h0);
        bus.frame(1'h0, 9, 1'h0, KIND_ARRAY, 8'h00, 8'h00, ok);
        repeat (2) @(posedge clk);
        check("bad select", active, 1'h0);
        print_verdict();
    end
endmodule
